// [common/lmco_pkg.sv]
// Shared constants and types for the logger output and duty measure block
package lmco_pkg;
  localparam int NUM_OUT = 3;
  localparam int NUM_IN = 4;
  localparam int CLK_HZ = 10000000;
  localparam int PER_W = 20;
  localparam int CYC_W = 44;
  localparam int DVD_W = 58;
  localparam int DP_W = 16;
  localparam int TOD_W = 17;
  localparam int ABS_W = 32;
  localparam int DUR_W = 16;
  localparam int DIV_W = 4;
  localparam int ALM_W = 8;
  localparam int STEP_W = 6;
  localparam logic [DP_W-1:0] FRAC_MIN = 16'h0000;
  localparam logic [DP_W-1:0] FRAC_MAX = 16'h2710;
  localparam logic [STEP_W-1:0] DIV_STEPS = 6'h3A;
  localparam logic [DIV_W-1:0] DIV_ONE = 4'h1;

  typedef enum logic [2:0] {
    LMCO_TOP_OFF = 3'h1,
    LMCO_TOP_MIRROR = 3'h2,
    LMCO_TOP_ADV = 3'h4
  } lmco_top_mode_t;

  typedef enum logic [4:0] {
    LMCO_OM_CONT = 5'h01,
    LMCO_OM_ALARM = 5'h02,
    LMCO_OM_TIME = 5'h04,
    LMCO_OM_PRE = 5'h08,
    LMCO_OM_SERPWR = 5'h10
  } lmco_out_mode_t;

  typedef enum logic [1:0] {
    LMCO_DV_IDLE = 2'h1,
    LMCO_DV_RUN = 2'h2
  } lmco_div_state_t;

  typedef struct packed {
    lmco_out_mode_t mode;
    logic pol_closed;
    logic single_shot;
    logic [ALM_W-1:0] alarm_sel;
    logic [TOD_W-1:0] start_tod;
    logic [TOD_W-1:0] end_tod;
    logic [ABS_W-1:0] start_abs;
    logic [ABS_W-1:0] end_abs;
    logic [DUR_W-1:0] pre_on_s;
    logic [DUR_W-1:0] post_s;
    logic [DIV_W-1:0] freq_div;
  } lmco_out_cfg_t;

  typedef struct packed {
    logic [TOD_W-1:0] tod;
    logic [ABS_W-1:0] abs_time;
    logic [PER_W-1:0] to_log;
    logic [PER_W-1:0] since_log;
    logic log_tick;
  } lmco_time_t;

  typedef struct packed {
    logic [DP_W-1:0] thresh;
    logic above;
  } lmco_trig_cfg_t;
endpackage

// [core/lmco_logger_out.sv]
// Top of the logger duty measure and output contact block
`timescale 1ns/1ns
// What this block does
// - Fraction datapoint scaled 0 to 10000
// - Closed option: open gives 0, closed 10000
// - Open option measures open time instead
// - One datapoint per configured log period
// - Hardware test shows raw uninverted pin
// - Triggers judged on datapoint when it is published after division
// - Off mode disables every output contact
// - Mirror mode copies input n to output n
// - Mirror covers status and meter pulse inputs
// - Each output has open or closed polarity
// - Continuous mode holds output active
// - Alarm mode active while selected alarm active
// - Daily window between start and end times
// - Single shot window on full date times
// - Pre-sample window before and after log time
// - Pre-sample windows reference log times only
// - Divider N: window every Nth log time
// - Serial power: pre-sample period only
module lmco_logger_out (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_sec_tick,
  input wire logic [lmco_pkg::PER_W-1:0] i_log_period_s,
  input wire logic [lmco_pkg::TOD_W-1:0] i_time_of_day,
  input wire logic [lmco_pkg::ABS_W-1:0] i_abs_time,
  input wire logic i_frac_pin,
  input wire logic i_frac_open,
  input wire lmco_pkg::lmco_trig_cfg_t i_trig_cfg,
  input wire lmco_pkg::lmco_top_mode_t i_top_mode,
  input wire lmco_pkg::lmco_out_cfg_t [lmco_pkg::NUM_OUT-1:0] i_out_cfg,
  input wire logic [lmco_pkg::ALM_W-1:0] i_alarms,
  input wire logic [lmco_pkg::NUM_IN-1:0] i_status_pins,
  input wire logic [lmco_pkg::NUM_IN-1:0] i_meter_pins,
  input wire logic [lmco_pkg::NUM_IN-1:0] i_in_is_flow,
  output logic o_log_tick,
  output logic [lmco_pkg::DP_W-1:0] o_datapoint,
  output logic o_dp_valid,
  output logic o_trig_active,
  output logic o_hw_test_raw,
  output logic [lmco_pkg::NUM_OUT-1:0] o_contact,
  output logic [lmco_pkg::NUM_OUT-1:0] o_contact_en
);
  import lmco_pkg::*;

  logic frac_meta_r;
  logic frac_sync_r;
  logic [NUM_IN-1:0] stat_meta_r;
  logic [NUM_IN-1:0] stat_sync_r;
  logic [NUM_IN-1:0] meter_meta_r;
  logic [NUM_IN-1:0] meter_sync_r;
  logic [NUM_IN-1:0] mirror_src;
  logic [PER_W-1:0] sec_cnt_r;
  logic log_now;
  lmco_time_t time_bus;
  logic [CYC_W-1:0] hit_cnt_r;
  logic [CYC_W-1:0] tot_cnt_r;
  logic in_cond;
  lmco_div_state_t dv_state_r;
  logic [DVD_W-1:0] dvd_r;
  logic [CYC_W-1:0] den_r;
  logic [CYC_W:0] rem_r;
  logic [CYC_W:0] rem_sh;
  logic [DVD_W-1:0] quo_r;
  logic [STEP_W-1:0] step_r;
  logic [DP_W-1:0] dp_nxt;
  logic [NUM_OUT-1:0] chan_active;
  logic dv_done_r;

  // Two-stage synchronisers for pins
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      frac_meta_r <= 1'b0;
      frac_sync_r <= 1'b0;
      stat_meta_r <= '0;
      stat_sync_r <= '0;
      meter_meta_r <= '0;
      meter_sync_r <= '0;
    end else if (i_clk_en) begin
      frac_meta_r <= i_frac_pin;
      frac_sync_r <= frac_meta_r;
      stat_meta_r <= i_status_pins;
      stat_sync_r <= stat_meta_r;
      meter_meta_r <= i_meter_pins;
      meter_sync_r <= meter_meta_r;
    end
  end

  // Raw pin level for hardware test
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_hw_test_raw <= 1'b0;
    end else if (i_clk_en) begin
      o_hw_test_raw <= frac_sync_r;
    end
  end

  // Log period timing from seconds ticks
  assign log_now = i_sec_tick && (32'(sec_cnt_r) + 32'd1 >= 32'(i_log_period_s));

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sec_cnt_r <= '0;
      o_log_tick <= 1'b0;
    end else if (i_clk_en) begin
      o_log_tick <= log_now;
      if (log_now) begin
        sec_cnt_r <= '0;
      end else if (i_sec_tick) begin
        sec_cnt_r <= sec_cnt_r + PER_W'(1);
      end
    end
  end

  assign time_bus.tod = i_time_of_day;
  assign time_bus.abs_time = i_abs_time;
  assign time_bus.to_log = i_log_period_s - sec_cnt_r;
  assign time_bus.since_log = sec_cnt_r;
  assign time_bus.log_tick = log_now;

  // Duty accumulation over the log period
  assign in_cond = i_frac_open ? !frac_sync_r : frac_sync_r;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hit_cnt_r <= '0;
      tot_cnt_r <= '0;
    end else if (i_clk_en) begin
      if (log_now) begin
        hit_cnt_r <= '0;
        tot_cnt_r <= '0;
      end else begin
        hit_cnt_r <= hit_cnt_r + CYC_W'(in_cond);
        tot_cnt_r <= tot_cnt_r + CYC_W'(1);
      end
    end
  end

  // Scaled division: hit times full scale over total
  assign rem_sh = {rem_r[CYC_W-1:0], dvd_r[DVD_W-1]};
  assign dp_nxt = (quo_r > DVD_W'(FRAC_MAX)) ? FRAC_MAX : quo_r[DP_W-1:0];

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dv_state_r <= LMCO_DV_IDLE;
      dvd_r <= '0;
      den_r <= '0;
      rem_r <= '0;
      quo_r <= '0;
      step_r <= '0;
    end else if (i_clk_en) begin
      case (dv_state_r)
        LMCO_DV_IDLE: begin
          if (log_now) begin
            dvd_r <= DVD_W'(hit_cnt_r) * DVD_W'(FRAC_MAX);
            den_r <= tot_cnt_r;
            rem_r <= '0;
            quo_r <= '0;
            step_r <= '0;
            dv_state_r <= LMCO_DV_RUN;
          end
        end
        LMCO_DV_RUN: begin
          dvd_r <= {dvd_r[DVD_W-2:0], 1'b0};
          if (den_r != '0 && rem_sh >= {1'b0, den_r}) begin
            rem_r <= rem_sh - {1'b0, den_r};
            quo_r <= {quo_r[DVD_W-2:0], 1'b1};
          end else begin
            rem_r <= rem_sh;
            quo_r <= {quo_r[DVD_W-2:0], 1'b0};
          end
          step_r <= step_r + STEP_W'(1);
          if (step_r == DIV_STEPS - STEP_W'(1)) begin
            dv_state_r <= LMCO_DV_IDLE;
          end
        end
        default: dv_state_r <= LMCO_DV_IDLE;
      endcase
    end
  end

  // Datapoint and trigger publishing
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_datapoint <= FRAC_MIN;
      o_dp_valid <= 1'b0;
      o_trig_active <= 1'b0;
    end else if (i_clk_en) begin
      o_dp_valid <= 1'b0;
      if (dv_done_r) begin
        o_datapoint <= (den_r == '0) ? FRAC_MIN : dp_nxt;
        o_dp_valid <= 1'b1;
        o_trig_active <= i_trig_cfg.above ? (dp_nxt > i_trig_cfg.thresh) : (dp_nxt < i_trig_cfg.thresh);
      end
    end
  end

  // One-cycle flag after last divider step
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dv_done_r <= 1'b0;
    end else if (i_clk_en) begin
      dv_done_r <= (dv_state_r == LMCO_DV_RUN) && (step_r == DIV_STEPS - STEP_W'(1));
    end
  end

  // Mirror sources by input kind
  assign mirror_src = (i_in_is_flow & meter_sync_r) | (~i_in_is_flow & stat_sync_r);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_chan
      lmco_out_chan u_chan (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_cfg(i_out_cfg[gi]),
        .i_time(time_bus),
        .i_alarms(i_alarms),
        .o_active(chan_active[gi])
      );
    end
  endgenerate

  // Contact drive per top-level mode
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_contact <= '0;
      o_contact_en <= '0;
    end else if (i_clk_en) begin
      case (i_top_mode)
        LMCO_TOP_OFF: begin
          o_contact <= '0;
          o_contact_en <= '0;
        end
        LMCO_TOP_MIRROR: begin
          o_contact <= mirror_src[NUM_OUT-1:0];
          o_contact_en <= '1;
        end
        LMCO_TOP_ADV: begin
          for (int k = 0; k < NUM_OUT; k++) begin
            o_contact[k] <= chan_active[k] ? i_out_cfg[k].pol_closed : !i_out_cfg[k].pol_closed;
          end
          o_contact_en <= '1;
        end
        default: begin
          o_contact <= '0;
          o_contact_en <= '0;
        end
      endcase
    end
  end

  property p_dp_range;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    o_dp_valid |-> (o_datapoint <= FRAC_MAX);
  endproperty
  a_dp_range: assert property (p_dp_range) else $error("datapoint above full scale");

  property p_full_closed;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_clk_en && log_now && dv_state_r == LMCO_DV_IDLE && hit_cnt_r == tot_cnt_r && tot_cnt_r != '0)
      |=> ##58 (i_clk_en && dv_state_r == LMCO_DV_IDLE) |-> (dp_nxt == FRAC_MAX);
  endproperty
  a_full_closed: assert property (p_full_closed) else $error("full period did not give full scale");

  property p_clear_at_log;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_clk_en && log_now) |=> (hit_cnt_r == '0 && tot_cnt_r == '0);
  endproperty
  a_clear_at_log: assert property (p_clear_at_log) else $error("accumulator not cleared at log");

  property p_dp_follows_log;
    @(posedge i_ref_clk) disable iff (i_sys_rst || !i_clk_en)
    (log_now && dv_state_r == LMCO_DV_IDLE) |-> ##[1:70] o_dp_valid;
  endproperty
  a_dp_follows_log: assert property (p_dp_follows_log) else $error("no datapoint after log time");

  property p_raw_ignores_open;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_clk_en && $past(i_clk_en) && $stable(frac_sync_r) && $changed(i_frac_open)) |=> $stable(o_hw_test_raw);
  endproperty
  a_raw_ignores_open: assert property (p_raw_ignores_open) else $error("raw test level moved with option");

  property p_off_mode;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_clk_en && i_top_mode == LMCO_TOP_OFF) |=> (o_contact == '0 && o_contact_en == '0);
  endproperty
  a_off_mode: assert property (p_off_mode) else $error("contact driven in off mode");

  property p_mirror;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_clk_en && i_top_mode == LMCO_TOP_MIRROR) |=> (o_contact == $past(mirror_src[NUM_OUT-1:0]));
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror contact mismatch");

  property p_trig_above;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (o_dp_valid && i_trig_cfg.above && i_trig_cfg.thresh >= FRAC_MAX) |-> !o_trig_active;
  endproperty
  a_trig_above: assert property (p_trig_above) else $error("trigger fired above reachable range");

  property p_inactive_opposite;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_clk_en && i_top_mode == LMCO_TOP_ADV && !chan_active[0]) |=> (o_contact[0] == !$past(i_out_cfg[0].pol_closed));
  endproperty
  a_inactive_opposite: assert property (p_inactive_opposite) else $error("inactive contact not opposite");

  property p_done_pulse;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    dv_done_r |-> (dv_state_r == LMCO_DV_IDLE);
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("divider still running when done");

  property p_dp_pulse;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_clk_en && o_dp_valid) |=> !o_dp_valid;
  endproperty
  a_dp_pulse: assert property (p_dp_pulse) else $error("datapoint strobe longer than one cycle");

  property p_log_tick;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_clk_en && log_now) |=> o_log_tick;
  endproperty
  a_log_tick: assert property (p_log_tick) else $error("log tick missing after boundary");

  property p_trig_below;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_clk_en && dv_done_r && !i_trig_cfg.above && i_trig_cfg.thresh <= FRAC_MIN) |=> !o_trig_active;
  endproperty
  a_trig_below: assert property (p_trig_below) else $error("trigger fired below reachable range");

  property p_raw_follows;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    i_clk_en |=> (o_hw_test_raw == $past(frac_sync_r));
  endproperty
  a_raw_follows: assert property (p_raw_follows) else $error("raw test level not the synchronised pin");

  property p_contact_enabled;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_clk_en && (i_top_mode == LMCO_TOP_MIRROR || i_top_mode == LMCO_TOP_ADV)) |=> (o_contact_en == '1);
  endproperty
  a_contact_enabled: assert property (p_contact_enabled) else $error("contact not enabled in use mode");
endmodule

// [core/lmco_out_chan.sv]
// One output channel: decides when the output is active in advanced mode
`timescale 1ns/1ns
module lmco_out_chan (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire lmco_pkg::lmco_out_cfg_t i_cfg,
  input wire lmco_pkg::lmco_time_t i_time,
  input wire logic [lmco_pkg::ALM_W-1:0] i_alarms,
  output logic o_active
);
  import lmco_pkg::*;

  logic [DIV_W-1:0] log_cnt_r;
  logic post_sel_r;
  logic next_sel;
  logic pre_win;
  logic post_win;
  logic tod_win;
  logic abs_win;
  logic active_nxt;

  // Upcoming log time is the Nth one
  assign next_sel = (i_cfg.freq_div <= DIV_ONE) || (log_cnt_r == i_cfg.freq_div - DIV_ONE);
  assign pre_win = (32'(i_time.to_log) <= 32'(i_cfg.pre_on_s));
  assign post_win = post_sel_r && (32'(i_time.since_log) < 32'(i_cfg.post_s));
  assign tod_win = (i_cfg.start_tod <= i_cfg.end_tod) ?
    (i_time.tod >= i_cfg.start_tod && i_time.tod < i_cfg.end_tod) :
    (i_time.tod >= i_cfg.start_tod || i_time.tod < i_cfg.end_tod);
  assign abs_win = (i_time.abs_time >= i_cfg.start_abs) && (i_time.abs_time < i_cfg.end_abs);

  // Divider count of log times
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      log_cnt_r <= '0;
      post_sel_r <= 1'b0;
    end else if (i_clk_en && i_time.log_tick) begin
      post_sel_r <= next_sel;
      log_cnt_r <= next_sel ? '0 : log_cnt_r + DIV_ONE;
    end
  end

  always_comb begin
    case (i_cfg.mode)
      LMCO_OM_CONT: active_nxt = 1'b1;
      LMCO_OM_ALARM: active_nxt = |(i_alarms & i_cfg.alarm_sel);
      LMCO_OM_TIME: active_nxt = i_cfg.single_shot ? abs_win : tod_win;
      LMCO_OM_PRE: active_nxt = (next_sel && pre_win) || post_win;
      LMCO_OM_SERPWR: active_nxt = pre_win;
      default: active_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_active <= 1'b0;
    end else if (i_clk_en) begin
      o_active <= active_nxt;
    end
  end

  property p_cont_active;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_clk_en && i_cfg.mode == LMCO_OM_CONT) |=> o_active;
  endproperty
  a_cont_active: assert property (p_cont_active) else $error("continuous output not active");

  property p_serpwr_no_post;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_clk_en && i_cfg.mode == LMCO_OM_SERPWR && 32'(i_time.to_log) > 32'(i_cfg.pre_on_s)) |=> !o_active;
  endproperty
  a_serpwr_no_post: assert property (p_serpwr_no_post) else $error("serial power active outside pre window");

  property p_alarm_follow;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_clk_en && i_cfg.mode == LMCO_OM_ALARM && (i_alarms & i_cfg.alarm_sel) == '0) |=> !o_active;
  endproperty
  a_alarm_follow: assert property (p_alarm_follow) else $error("alarm output active with no alarm");
endmodule

// [tb/lmco_equip.sv]
// Model of the external equipment switched by the output contacts
`timescale 1ns/1ns
module lmco_equip (
  input wire logic [lmco_pkg::NUM_OUT-1:0] i_contact,
  input wire logic [lmco_pkg::NUM_OUT-1:0] i_contact_en,
  output logic [lmco_pkg::NUM_OUT-1:0] o_powered
);
  import lmco_pkg::*;
  // Load powered only by a closed contact in use
  assign o_powered = i_contact & i_contact_en;
endmodule

// [tb/testbench.sv]
// Self-checking testbench for the logger output and duty measure block
`timescale 1ns/1ns
module testbench;
  import lmco_pkg::*;
  logic i_ref_clk, i_sys_rst, i_clk_en, i_sec_tick, i_frac_pin, i_frac_open;
  logic [PER_W-1:0] i_log_period_s;
  logic [TOD_W-1:0] i_time_of_day;
  logic [ABS_W-1:0] i_abs_time;
  lmco_trig_cfg_t i_trig_cfg;
  lmco_top_mode_t i_top_mode;
  lmco_out_cfg_t [NUM_OUT-1:0] i_out_cfg;
  lmco_out_cfg_t base;
  logic [ALM_W-1:0] i_alarms;
  logic [NUM_IN-1:0] i_status_pins, i_meter_pins, i_in_is_flow;
  logic o_log_tick, o_dp_valid, o_trig_active, o_hw_test_raw;
  logic [DP_W-1:0] o_datapoint;
  logic [NUM_OUT-1:0] o_contact, o_contact_en, powered;
  int fails = 0;
  int compares = 0;
  int sec_cnt = 0;

  lmco_logger_out u_lmco_logger_out (.i_ref_clk, .i_sys_rst, .i_clk_en, .i_sec_tick, .i_log_period_s,
    .i_time_of_day, .i_abs_time, .i_frac_pin, .i_frac_open, .i_trig_cfg, .i_top_mode, .i_out_cfg,
    .i_alarms, .i_status_pins, .i_meter_pins, .i_in_is_flow, .o_log_tick, .o_datapoint, .o_dp_valid,
    .o_trig_active, .o_hw_test_raw, .o_contact, .o_contact_en);
  lmco_equip u_lmco_equip (.i_contact(o_contact), .i_contact_en(o_contact_en), .o_powered(powered));

  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  // Second tick every 100 cycles
  always @(negedge i_ref_clk) begin
    sec_cnt <= (sec_cnt == 99) ? 0 : sec_cnt + 1;
    i_sec_tick <= (sec_cnt == 99);
  end

  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_c(input logic [NUM_OUT-1:0] got, input logic [NUM_OUT-1:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  // Wait for log tick or datapoint pulse, bounded
  task automatic wait_ev(input bit log_ev);
    int n;
    for (n = 0; n < 2000; n++) begin
      @(negedge i_ref_clk);
      if ((log_ev ? o_log_tick : o_dp_valid) === 1'b1) return;
    end
    fails++;
    summarize();
  endtask

  task automatic new_dp(input logic [15:0] exp);
    wait_ev(1'b0);
    wait_ev(1'b0);
    chk_v(o_datapoint, exp);
  endtask

  task automatic adv_chk(input logic act);
    i_out_cfg = {NUM_OUT{base}};
    cyc(4);
    chk_c(o_contact, {NUM_OUT{act == base.pol_closed}});
  endtask

  task automatic t_duty;
    i_frac_pin = 1'b1;
    new_dp(FRAC_MAX);
    chk_c({2'h0, o_hw_test_raw}, 3'h1);
    i_trig_cfg = '{thresh: FRAC_MAX, above: 1'b1};
    wait_ev(1'b0);
    chk_c({2'h0, o_trig_active}, 3'h0);
    i_trig_cfg = '{thresh: 16'h270F, above: 1'b1};
    wait_ev(1'b0);
    chk_c({2'h0, o_trig_active}, 3'h1);
    i_frac_open = 1'b1;
    new_dp(FRAC_MIN);
    chk_c({2'h0, o_hw_test_raw}, 3'h1);
    i_frac_open = 1'b0;
    i_frac_pin = 1'b0;
    i_trig_cfg = '{thresh: FRAC_MIN, above: 1'b0};
    new_dp(FRAC_MIN);
    chk_c({2'h0, o_trig_active}, 3'h0);
  endtask

  task automatic t_period;
    int n;
    i_log_period_s = 20'h00002;
    wait_ev(1'b1);
    wait_ev(1'b1);
    @(negedge i_ref_clk);
    for (n = 1; n < 1000 && o_log_tick !== 1'b1; n++) begin
      @(negedge i_ref_clk);
    end
    chk_v(16'(n), 16'h00C8);
  endtask

  task automatic t_off_mirror;
    int k;
    i_top_mode = LMCO_TOP_OFF;
    cyc(4);
    chk_c(o_contact_en, 3'h0);
    chk_c(powered, 3'h0);
    i_top_mode = LMCO_TOP_MIRROR;
    i_in_is_flow = 4'h6;
    for (k = 0; k < 2; k++) begin
      i_status_pins = k ? 4'h5 : 4'hA;
      i_meter_pins = ~i_status_pins;
      cyc(5);
      chk_c(o_contact, 3'((i_in_is_flow & i_meter_pins) | (~i_in_is_flow & i_status_pins)));
    end
    i_clk_en = 1'b0;
    i_status_pins = 4'hA;
    i_meter_pins = 4'h5;
    cyc(5);
    chk_c(o_contact, 3'h3);
    i_clk_en = 1'b1;
    cyc(5);
    chk_c(o_contact, 3'h4);
  endtask

  task automatic t_adv;
    int p;
    i_top_mode = LMCO_TOP_ADV;
    for (p = 0; p < 2; p++) begin
      base.pol_closed = p[0];
      base.mode = LMCO_OM_CONT;
      adv_chk(1'b1);
      chk_c(powered, o_contact);
      base.mode = LMCO_OM_ALARM;
      i_alarms = 8'hFB;
      adv_chk(1'b0);
      i_alarms = 8'h04;
      adv_chk(1'b1);
    end
    base.mode = LMCO_OM_TIME;
    i_time_of_day = 17'h00096;
    adv_chk(1'b1);
    i_time_of_day = 17'h000C8;
    adv_chk(1'b0);
    base.start_tod = 17'h000C8;
    base.end_tod = 17'h00064;
    i_time_of_day = 17'h00032;
    adv_chk(1'b1);
    base.single_shot = 1'b1;
    i_abs_time = 32'h000005DC;
    adv_chk(1'b1);
    i_abs_time = 32'h000007D0;
    adv_chk(1'b0);
  endtask

  task automatic t_pre;
    int k;
    int hits;
    hits = 0;
    i_log_period_s = 20'h00004;
    base.mode = LMCO_OM_PRE;
    wait_ev(1'b1);
    adv_chk(1'b1);
    cyc(50);
    chk_c(o_contact, 3'h7);
    cyc(150);
    chk_c(o_contact, 3'h0);
    cyc(150);
    chk_c(o_contact, 3'h7);
    base.mode = LMCO_OM_SERPWR;
    adv_chk(1'b1);
    wait_ev(1'b1);
    cyc(50);
    chk_c(o_contact, 3'h0);
    cyc(300);
    chk_c(o_contact, 3'h7);
    base.mode = LMCO_OM_PRE;
    base.freq_div = 4'h3;
    adv_chk(1'b0);
    for (k = 0; k < 6; k++) begin
      wait_ev(1'b1);
      cyc(50);
      if (o_contact[0] === 1'b1) hits++;
    end
    chk_v(16'(hits), 16'h0002);
  endtask

  initial begin
    i_sys_rst = 1'b1;
    i_clk_en = 1'b1;
    i_sec_tick = 1'b0;
    i_frac_pin = 1'b0;
    i_frac_open = 1'b0;
    i_log_period_s = 20'h00001;
    i_time_of_day = 17'h00000;
    i_abs_time = 32'h00000000;
    i_trig_cfg = '{thresh: FRAC_MAX, above: 1'b1};
    i_top_mode = LMCO_TOP_OFF;
    base = '0;
    base.mode = LMCO_OM_CONT;
    base.freq_div = DIV_ONE;
    base.pre_on_s = 16'h0001;
    base.post_s = 16'h0001;
    base.alarm_sel = 8'h04;
    base.start_tod = 17'h00064;
    base.end_tod = 17'h000C8;
    base.start_abs = 32'h000003E8;
    base.end_abs = 32'h000007D0;
    i_out_cfg = {NUM_OUT{base}};
    i_alarms = 8'h00;
    i_status_pins = 4'h0;
    i_meter_pins = 4'h0;
    i_in_is_flow = 4'h0;
    cyc(20);
    chk_c(o_contact | o_contact_en, 3'h0);
    chk_v(o_datapoint, 16'h0000);
    i_sys_rst = 1'b0;
    t_duty();
    t_period();
    t_off_mirror();
    t_adv();
    t_pre();
    summarize();
  end
endmodule
